// *** src/dic_pkg.sv ***
`default_nettype none
package dic_pkg;
  // Register address map of this slice
  localparam logic [7:0] ADDR_WORD_FOUR  = 8'h0D;
  localparam logic [7:0] ADDR_WORD_FIVE  = 8'h0E;
  localparam logic [7:0] ADDR_WORD_SIX   = 8'h0F;
  localparam logic [7:0] ADDR_WORD_SEVEN = 8'h10;
  localparam logic [7:0] ADDR_ALARM_CTRL = 8'h11;
  localparam logic [7:0] ADDR_INV_SYNC   = 8'h12;

  // Reset values
  localparam logic [7:0] RST_WORD_FOUR   = 8'h1A;
  localparam logic [7:0] RST_WORD_FIVE   = 8'h16;
  localparam logic [7:0] RST_WORD_SIX    = 8'hAA;
  localparam logic [7:0] RST_WORD_SEVEN  = 8'hC6;
  localparam logic [7:0] RST_ALARM_CTRL  = 8'h24;
  localparam logic [7:0] RST_INV_SYNC    = 8'h02;

  // Alarm control field positions
  localparam int BIT_CLK_ALARM_MASK = 4;
  localparam int BIT_TX_OFF_MASK    = 3;
  localparam int BIT_CLK_ALARM_ENA  = 1;
  localparam int BIT_AUTO_MUTE_ENA  = 0;

  // Inversion / sync field positions
  localparam int BIT_INVERT_A       = 3;
  localparam int BIT_INVERT_B       = 2;
  localparam int BIT_DIV_SYNC_ENA   = 1;

  // Writable bits and reserved bits that read as constant ones
  localparam logic [7:0] ALARM_CTRL_WMASK = 8'h1B;
  localparam logic [7:0] ALARM_CTRL_FIXED = 8'h24;
  localparam logic [7:0] INV_SYNC_WMASK   = 8'h0E;

  // Pattern checker geometry
  localparam int PATTERN_WORDS      = 8;
  localparam int PATTERN_IDX_W      = 3;
  localparam logic [2:0] IDX_LAST   = 3'h7;
  localparam logic [2:0] IDX_FIRST  = 3'h0;

  // Sync source select encoding
  localparam logic SYNC_SRC_STROBE  = 1'b0;
  localparam logic SYNC_SRC_FRAME   = 1'b1;
endpackage : dic_pkg
`default_nettype wire

// *** src/dic_pattern_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module dic_pattern_checker
  import dic_pkg::*;
#(
  parameter int WORD_W = 8
)
(
  input  wire logic                             sys_clk,
  input  wire logic                             nrst,
  input  wire logic                             ce,
  input  wire logic [dic_pkg::PATTERN_WORDS*WORD_W-1:0] patternWords,
  input  wire logic                             restart,
  input  wire logic                             inValid,
  input  wire logic [WORD_W-1:0]                inData,
  output logic                                  mismatch
);
  import dic_pkg::*;

  logic [PATTERN_IDX_W-1:0] idx_q;
  logic [PATTERN_IDX_W-1:0] idx_d;
  logic [WORD_W-1:0]        expected;
  logic                     mismatch_d;

  // Expected word selected by the running index
  assign expected   = patternWords[idx_q*WORD_W +: WORD_W];
  assign idx_d      = restart ? IDX_FIRST : (idx_q == IDX_LAST) ? IDX_FIRST : idx_q + 3'h1;
  assign mismatch_d = inValid && (inData != expected);

  // Index walks the eight words; a restart realigns to word zero
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      idx_q    <= IDX_FIRST;
      mismatch <= 1'b0;
    end
    else if (ce)
    begin
      if (inValid || restart)
        idx_q <= idx_d;
      mismatch <= mismatch_d; // One-cycle pulse per bad word
    end
  end
endmodule // dic_pattern_checker
`default_nettype wire

// *** src/dic_alarm_ctrl.sv ***
// Summary of operation
// - Register at 0x0D holds pattern word four, reset 0x1A, used by checker.
// - Register at 0x0E holds pattern word five, reset 0x16, used by checker.
// - Register at 0x0F holds pattern word six, reset 0xAA, used by checker.
// - Register at 0x10 holds pattern word seven, reset 0xC6, used by checker.
// - Clock monitor mask bit set keeps that alarm off the alarm pin.
// - Masked clock monitor alarm still sets its fault status flag.
// - Output-disable mask bit set keeps that alarm off the alarm pin.
// - Masked output-disable alarm still sets its status flag.
// - Clock monitor alarm only raised while its enable bit is set; resets zero.
// - Auto mute enable forces both outputs to midscale on clock alarm.
// - Channel A inversion bit complements data sent to converter A.
// - Channel B inversion bit complements data sent to converter B.
// - Divider sync enable lets strobe or frame marker sync the divider.
// - Sync source chosen by external select bit from another register.
// - Inversion and sync control register reads 0x02 after reset.
// - Mismatch flag set whenever received data differs from pattern.
// - Select 0 picks external strobe, select 1 picks buffered frame marker.
`timescale 1ns/100ps
`default_nettype none
module dic_alarm_ctrl
  import dic_pkg::*;
#(
  parameter int DAC_W  = 16,
  parameter int WORD_W = 8
)
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  // Register port of the serial control interface
  input  wire logic [7:0]        regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWrEn,
  input  wire logic              regRdEn,
  output logic [7:0]             regRdData,
  output logic                   regRdValid,
  // Pattern words zero to three held elsewhere
  input  wire logic [WORD_W-1:0] checkWordZero,
  input  wire logic [WORD_W-1:0] checkWordOne,
  input  wire logic [WORD_W-1:0] checkWordTwo,
  input  wire logic [WORD_W-1:0] checkWordThree,
  // Incoming interface words for the checker
  input  wire logic              inValid,
  input  wire logic [WORD_W-1:0] inData,
  output logic                   patternMismatch,
  // Alarm sources and status
  input  wire logic              clockMonitorFault,
  input  wire logic              outputDisableEvent,
  input  wire logic              clkFaultClear,
  input  wire logic              txOffClear,
  output logic                   clkFaultFlag,
  output logic                   txOffFlag,
  output logic                   alarmOutputPin,
  // Converter data path
  input  wire logic [DAC_W-1:0]  dacDataInA,
  input  wire logic [DAC_W-1:0]  dacDataInB,
  output logic [DAC_W-1:0]       dacDataOutA,
  output logic [DAC_W-1:0]       dacDataOutB,
  output logic                   muteActive,
  // Divider synchronisation
  input  wire logic              syncSourceSel,
  input  wire logic              externalSyncStrobe,
  input  wire logic              frameMarker,
  output logic                   dividerSync
);
  import dic_pkg::*;

  // Refuse widths the data path cannot serve
  generate
    if (DAC_W < 2 || WORD_W != 8)
    begin : g_bad_param
      $error("dic_alarm_ctrl: DAC_W must be at least 2 and WORD_W must be 8");
    end
  endgenerate

  localparam logic [DAC_W-1:0] MIDSCALE = {1'b1, {(DAC_W-1){1'b0}}};

  // Register state
  logic [7:0] wordFour_q;
  logic [7:0] wordFive_q;
  logic [7:0] wordSix_q;
  logic [7:0] wordSeven_q;
  logic [7:0] alarmCtrl_q;
  logic [7:0] invSync_q;
  logic [7:0] alarmCtrl_d;
  logic [7:0] invSync_d;

  // Status and mute state
  logic       clkFault_d;
  logic       txOff_d;
  logic       mute_d;
  logic       alarm_d;
  logic [7:0] rdData_d;

  // Address decode helper, used by both the write decode and the read mux
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  wire wrWordFour  = regWrEn && hit(regAddr, ADDR_WORD_FOUR);
  wire wrWordFive  = regWrEn && hit(regAddr, ADDR_WORD_FIVE);
  wire wrWordSix   = regWrEn && hit(regAddr, ADDR_WORD_SIX);
  wire wrWordSeven = regWrEn && hit(regAddr, ADDR_WORD_SEVEN);
  wire wrAlarmCtrl = regWrEn && hit(regAddr, ADDR_ALARM_CTRL);
  wire wrInvSync   = regWrEn && hit(regAddr, ADDR_INV_SYNC);

  // Control fields
  wire clkAlarmMask = alarmCtrl_q[BIT_CLK_ALARM_MASK];
  wire txOffMask    = alarmCtrl_q[BIT_TX_OFF_MASK];
  wire clkAlarmEna  = alarmCtrl_q[BIT_CLK_ALARM_ENA];
  wire autoMuteEna  = alarmCtrl_q[BIT_AUTO_MUTE_ENA];
  wire invertA      = invSync_q[BIT_INVERT_A];
  wire invertB      = invSync_q[BIT_INVERT_B];
  wire divSyncEna   = invSync_q[BIT_DIV_SYNC_ENA];

  // Reserved bits are not stored; fixed ones are forced in on every write
  assign alarmCtrl_d = (regWrData & ALARM_CTRL_WMASK) | ALARM_CTRL_FIXED;
  assign invSync_d   = regWrData & INV_SYNC_WMASK;

  // Pattern word registers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wordFour_q  <= RST_WORD_FOUR;
      wordFive_q  <= RST_WORD_FIVE;
      wordSix_q   <= RST_WORD_SIX;
      wordSeven_q <= RST_WORD_SEVEN;
    end
    else if (ce)
    begin
      if (wrWordFour)
        wordFour_q <= regWrData;
      if (wrWordFive)
        wordFive_q <= regWrData;
      if (wrWordSix)
        wordSix_q <= regWrData;
      if (wrWordSeven)
        wordSeven_q <= regWrData;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      alarmCtrl_q <= RST_ALARM_CTRL;
      invSync_q   <= RST_INV_SYNC;
    end
    else if (ce)
    begin
      if (wrAlarmCtrl)
        alarmCtrl_q <= alarmCtrl_d;
      if (wrInvSync)
        invSync_q <= invSync_d;
    end
  end

  // Read mux; unmapped addresses answer zero
  assign rdData_d = hit(regAddr, ADDR_WORD_FOUR)  ? wordFour_q  :
                    hit(regAddr, ADDR_WORD_FIVE)  ? wordFive_q  :
                    hit(regAddr, ADDR_WORD_SIX)   ? wordSix_q   :
                    hit(regAddr, ADDR_WORD_SEVEN) ? wordSeven_q :
                    hit(regAddr, ADDR_ALARM_CTRL) ? alarmCtrl_q :
                    hit(regAddr, ADDR_INV_SYNC)   ? invSync_q   : 8'h00;

  // Read data registered so the port never glitches
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      regRdData  <= 8'h00;
      regRdValid <= 1'b0;
    end
    else if (ce)
    begin
      regRdValid <= regRdEn;
      if (regRdEn)
        regRdData <= rdData_d;
    end
  end

  // Clock monitor fault only counts while the monitor is enabled
  wire clkAlarmEvent = clockMonitorFault && clkAlarmEna;

  // Sticky status; a new event wins over a clear in the same cycle
  assign clkFault_d = clkAlarmEvent || (clkFaultFlag && !clkFaultClear);
  assign txOff_d    = outputDisableEvent || (txOffFlag && !txOffClear);

  // Masks gate only the pin, never the status flags
  assign alarm_d = (clkFault_d && !clkAlarmMask)
                || (txOff_d && !txOffMask);

  // Mute holds from the alarm until the fault flag is cleared
  assign mute_d = autoMuteEna && clkFault_d;

  // Status, pin and mute registers
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clkFaultFlag   <= 1'b0;
      txOffFlag      <= 1'b0;
      alarmOutputPin <= 1'b0;
      muteActive     <= 1'b0;
    end
    else if (ce)
    begin
      clkFaultFlag   <= clkFault_d;
      txOffFlag      <= txOff_d;
      alarmOutputPin <= alarm_d;
      muteActive     <= mute_d;
    end
  end

  // Converter data: mute overrides inversion, evaluated on the same edge
  wire [DAC_W-1:0] dataA_d = mute_d ? MIDSCALE : (invertA ? ~dacDataInA : dacDataInA);
  wire [DAC_W-1:0] dataB_d = mute_d ? MIDSCALE : (invertB ? ~dacDataInB : dacDataInB);

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dacDataOutA <= MIDSCALE;
      dacDataOutB <= MIDSCALE;
    end
    else if (ce)
    begin
      dacDataOutA <= dataA_d;
      dacDataOutB <= dataB_d;
    end
  end

  // Sync source choice; select comes from a register outside this slice
  wire syncSource = (syncSourceSel == SYNC_SRC_FRAME) ? frameMarker : externalSyncStrobe;
  // Left enabled by default; software is expected to drop it after init
  wire sync_d     = divSyncEna && syncSource;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      dividerSync <= 1'b0;
    else if (ce)
      dividerSync <= sync_d;
  end

  // A divider sync also realigns the checker to word zero
  wire [PATTERN_WORDS*WORD_W-1:0] allWords = {wordSeven_q, wordSix_q, wordFive_q, wordFour_q,
                                              checkWordThree, checkWordTwo, checkWordOne, checkWordZero};

  dic_pattern_checker #(
    .WORD_W       (WORD_W)
  ) u_checker (
    .sys_clk      (sys_clk),
    .nrst         (nrst),
    .ce           (ce),
    .patternWords (allWords),
    .restart      (sync_d),
    .inValid      (inValid),
    .inData       (inData),
    .mismatch     (patternMismatch)
  );
endmodule // dic_alarm_ctrl
`default_nettype wire

// *** testbench/dic_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module dic_host_model
(
  input  wire logic  sys_clk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic       regWrEn,
  output logic       regRdEn
);
  // Bus idle with both strobes low from time zero
  initial
  begin
    regAddr   = 8'h00;
    regWrData = 8'h00;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
  end

  // One access per call; a full cycle is held so the edge surely takes it
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    regAddr   = a;
    regWrData = d;
    regWrEn   = wr;
    regRdEn   = ~wr;
    @(negedge sys_clk);
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    // Released bus shows no leftover value
    regAddr   = ~a;
    regWrData = ~d;
  endtask
endmodule // dic_host_model
`default_nettype wire

// *** testbench/dic_alarm_ctrl_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module dic_alarm_ctrl_chk
  import dic_pkg::*;
#(
  parameter int DAC_W = 16
)
(
  input wire logic             sys_clk,
  input wire logic             nrst,
  input wire logic             ce,
  input wire logic [7:0]       regAddr,
  input wire logic [7:0]       regWrData,
  input wire logic             regWrEn,
  input wire logic             clockMonitorFault,
  input wire logic             outputDisableEvent,
  input wire logic             clkFaultFlag,
  input wire logic             txOffFlag,
  input wire logic             alarmOutputPin,
  input wire logic             muteActive,
  input wire logic [DAC_W-1:0] dacDataInA,
  input wire logic [DAC_W-1:0] dacDataInB,
  input wire logic [DAC_W-1:0] dacDataOutA,
  input wire logic [DAC_W-1:0] dacDataOutB,
  input wire logic             syncSourceSel,
  input wire logic             externalSyncStrobe,
  input wire logic             frameMarker,
  input wire logic             dividerSync
);
  import dic_pkg::*;

  localparam logic [DAC_W-1:0] MIDSCALE = {1'b1, {(DAC_W-1){1'b0}}};
  logic [7:0] shAlm_q;
  logic [7:0] shInv_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // Shadow copies of the two control registers, same write timing as the block
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shAlm_q <= RST_ALARM_CTRL;
      shInv_q <= RST_INV_SYNC;
    end
    else if (ce && regWrEn && regAddr == ADDR_ALARM_CTRL)
      shAlm_q <= (regWrData & ALARM_CTRL_WMASK) | ALARM_CTRL_FIXED;
    else if (ce && regWrEn && regAddr == ADDR_INV_SYNC)
      shInv_q <= regWrData & INV_SYNC_WMASK;
  end

  // Pin is judged against the mask that stood at the edge which launched it
  AST_CLK_MASKED: assert property ((ce && shAlm_q[4]) ##1 (clkFaultFlag && !txOffFlag) |-> !alarmOutputPin)
    else $error("masked clock alarm on pin");
  AST_CLK_UNMASKED: assert property ((ce && !shAlm_q[4]) ##1 clkFaultFlag |-> alarmOutputPin)
    else $error("clock alarm missing on pin");
  AST_CLK_FLAG: assert property (ce && clockMonitorFault && shAlm_q[1] |=> clkFaultFlag)
    else $error("clock fault flag not set");
  AST_TX_MASKED: assert property ((ce && shAlm_q[3]) ##1 (txOffFlag && !clkFaultFlag) |-> !alarmOutputPin)
    else $error("masked output-disable alarm on pin");
  AST_TX_FLAG: assert property (ce && outputDisableEvent |=> txOffFlag)
    else $error("output-disable flag not set");
  AST_CLK_ENA: assert property (ce && !shAlm_q[1] && !clkFaultFlag |=> !clkFaultFlag)
    else $error("clock alarm raised while disabled");
  AST_AUTO_MUTE: assert property (ce && clockMonitorFault && shAlm_q[1:0] == 2'b11 |=> muteActive
    && dacDataOutA == MIDSCALE && dacDataOutB == MIDSCALE)
    else $error("outputs not muted to midscale");
  AST_INV_A: assert property (ce ##1 !muteActive |-> dacDataOutA ==
    ($past(shInv_q[3]) ? ~$past(dacDataInA) : $past(dacDataInA)))
    else $error("channel A data wrong");
  AST_INV_B: assert property (ce ##1 !muteActive |-> dacDataOutB ==
    ($past(shInv_q[2]) ? ~$past(dacDataInB) : $past(dacDataInB)))
    else $error("channel B data wrong");
  AST_DIV_SYNC: assert property (ce |=> dividerSync ==
    $past(shInv_q[1] && (syncSourceSel ? frameMarker : externalSyncStrobe)))
    else $error("divider sync wrong");
endmodule // dic_alarm_ctrl_chk

bind dic_alarm_ctrl dic_alarm_ctrl_chk #(.DAC_W(DAC_W)) u_dic_alarm_ctrl_chk (.sys_clk, .nrst, .ce, .regAddr,
  .regWrData, .regWrEn, .clockMonitorFault, .outputDisableEvent, .clkFaultFlag, .txOffFlag, .alarmOutputPin,
  .muteActive, .dacDataInA, .dacDataInB, .dacDataOutA, .dacDataOutB, .syncSourceSel, .externalSyncStrobe,
  .frameMarker, .dividerSync);
`default_nettype wire

// *** testbench/dic_alarm_ctrl_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module dic_alarm_ctrl_tb;
  import dic_pkg::*;
  logic        sys_clk, nrst, ce, regWrEn, regRdEn, regRdValid, inValid, patternMismatch, pvld;
  logic        clockMonitorFault, outputDisableEvent, clkFaultClear, txOffClear, clkFaultFlag, txOffFlag;
  logic        alarmOutputPin, muteActive, syncSourceSel, externalSyncStrobe, frameMarker, dividerSync, bad;
  logic [7:0]  regAddr, regWrData, regRdData, inData, d, e;
  logic [15:0] dacDataInA, dacDataInB, dacDataOutA, dacDataOutB;
  logic [7:0]  pat [8];
  logic [7:0]  rdQ [$];
  logic        misQ [$];
  integer      seed, num_errors, n_tests, i, k;
  logic [7:0]  rstv [6] = '{RST_WORD_FOUR, RST_WORD_FIVE, RST_WORD_SIX, RST_WORD_SEVEN, RST_ALARM_CTRL, RST_INV_SYNC};

  dic_alarm_ctrl u_dic_alarm_ctrl (.sys_clk, .nrst, .ce, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
    .regRdValid, .checkWordZero(pat[0]), .checkWordOne(pat[1]), .checkWordTwo(pat[2]), .checkWordThree(pat[3]),
    .inValid, .inData, .patternMismatch, .clockMonitorFault, .outputDisableEvent, .clkFaultClear, .txOffClear,
    .clkFaultFlag, .txOffFlag, .alarmOutputPin, .dacDataInA, .dacDataInB, .dacDataOutA, .dacDataOutB, .muteActive,
    .syncSourceSel, .externalSyncStrobe, .frameMarker, .dividerSync);
  dic_host_model u_dic_host_model (.sys_clk, .regAddr, .regWrData, .regWrEn, .regRdEn);

  task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic stop_test;
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Read notes its expectation first; the monitor pairs it with regRdValid
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    rdQ.push_back(x);
    u_dic_host_model.access(1'b0, a, 8'h00);
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Clock and watchdog; the run needs well under 2000 cycles
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #(2000 * 25);
    num_errors++;
    stop_test();
  end

  // Random converter data every cycle to exercise inversion and mute
  always @(negedge sys_clk)
  begin
    dacDataInA <= $random(seed);
    dacDataInB <= $random(seed);
  end

  // Result monitor: read data and per-word checker outcome
  always @(posedge sys_clk)
  begin
    if (regRdValid === 1'b1) cmp("regRdData", rdQ.pop_front(), regRdData);
    if (pvld) cmp("patternMismatch", misQ.pop_front(), patternMismatch);
    pvld = (nrst === 1'b1) && (inValid === 1'b1);
  end

  initial
  begin
    seed = 5;
    {num_errors, n_tests, pvld} = '0;
    {nrst, inValid, clockMonitorFault, outputDisableEvent, clkFaultClear, txOffClear} = '0;
    {syncSourceSel, externalSyncStrobe, frameMarker, inData, dacDataInA, dacDataInB} = '0;
    ce = 1'b1;
    for (k = 0; k < 8; k++) pat[k] = $random(seed);
    step(10);
    nrst = 1'b1;
    for (k = 0; k < 6; k++) rd(ADDR_WORD_FOUR + 8'(k), rstv[k]);
    // Sync during initialisation: unselected source first, then selected
    for (k = 0; k < 4; k++)
    begin
      u_dic_host_model.access(1'b1, ADDR_INV_SYNC, {6'h0, k[1], 1'b0});
      syncSourceSel = k[0];
      {externalSyncStrobe, frameMarker} = {k[0], ~k[0]};
      step(1);
      cmp("dividerSync", 16'h0, dividerSync);
      {externalSyncStrobe, frameMarker} = {~k[0], k[0]};
      step(1);
      cmp("dividerSync", 16'(k[1]), dividerSync);
      {externalSyncStrobe, frameMarker} = 2'b00;
    end
    u_dic_host_model.access(1'b1, ADDR_INV_SYNC, 8'h00);
    // Back-to-back write and read, then unmapped places
    for (k = 0; k < 6; k++)
    begin
      d = $random(seed);
      e = (k == 4) ? ((d & ALARM_CTRL_WMASK) | ALARM_CTRL_FIXED) : (k == 5) ? (d & INV_SYNC_WMASK) : d;
      if (k < 4) pat[k + 4] = d;
      u_dic_host_model.access(1'b1, ADDR_WORD_FOUR + 8'(k), d);
      rd(ADDR_WORD_FOUR + 8'(k), e);
    end
    u_dic_host_model.access(1'b1, 8'h13, 8'hFF);
    rd(8'h13, 8'h00);
    rd(8'h0C, 8'h00);
    // Pattern stream with gaps and single-bit corruptions; index starts at zero
    k = 0;
    for (i = 0; i < 40; i++)
    begin
      inValid = ($random(seed) & 3) != 0;
      bad = ($random(seed) & 3) == 0;
      inData = inValid ? pat[k % 8] ^ (bad ? 8'h01 << ($random(seed) & 7) : 8'h00) : 8'($random(seed));
      if (inValid)
      begin
        misQ.push_back(bad);
        k++;
      end
      step(1);
    end
    inValid = 1'b0;
    // Each mask pair against both alarm sources
    for (k = 0; k < 5; k++)
    begin
      u_dic_host_model.access(1'b1, ADDR_ALARM_CTRL, (k == 4) ? 8'h00 : {3'h0, k[1:0], 3'h3});
      clockMonitorFault = 1'b1;
      step(1);
      clockMonitorFault = 1'b0;
      cmp("clkFaultFlag", 16'(k < 4), clkFaultFlag);
      cmp("alarmOutputPin", 16'(k < 4 && !k[1]), alarmOutputPin);
      cmp("muteActive", 16'(k < 4), muteActive);
      if (k < 4) cmp("dacDataOutA", 16'h8000, dacDataOutA);
      if (k < 4) cmp("dacDataOutB", 16'h8000, dacDataOutB);
      {clkFaultClear, outputDisableEvent} = 2'b11;
      step(1);
      {clkFaultClear, outputDisableEvent} = 2'b00;
      cmp("alarmOutputPin", 16'(!k[0] || k == 4), alarmOutputPin);
      txOffClear = 1'b1;
      step(1);
      txOffClear = 1'b0;
      cmp("txOffFlag", 16'h0, txOffFlag);
    end
    // Writes are ignored while the clock enable is low
    ce = 1'b0;
    u_dic_host_model.access(1'b1, ADDR_WORD_FOUR, ~pat[4]);
    ce = 1'b1;
    rd(ADDR_WORD_FOUR, pat[4]);
    step(3);
    stop_test();
  end
endmodule // dic_alarm_ctrl_tb
`default_nettype wire
